// ### src/asc_adc_sequencer_control.sv
// Purpose: Control logic for a 12-bit converter: registers, start detect, clock divider, sequencing.
// Assumes: The converter core runs on pclk and holds its 12-bit result valid at completion.
// Notes:   APB answers with zero wait states; unmapped addresses answer with pslverr.
//
// Operation
// RQ1: A conversion starts only when the start bit is written high, then low.
// RQ2: Busy flag at bit 6 reads 1 from initiation until the conversion completes.
// RQ3: Completion sets the interrupt flag and pulses the interrupt signal as busy clears.
// RQ4: With interrupts off, software polls the busy flag until it reads zero.
// RQ5: Bit 5 enables the converter; disabled, both result registers stay unchanged.
// RQ6: Format 0 puts bits 11..4 high, 3..0 low; format 1 puts 11..8 high, 7..0 low.
// RQ7: Channel codes 0 to 7 route an external input; codes 8 to 15 route none.
// RQ8: Source 001 selects bandgap, 010 to 100 ground, other codes the external channel.
// RQ9: An internal source always disconnects the external channel input.
// RQ10: Reference code 01 selects the converter supply; other codes the reference pin.
// RQ11: Choosing the supply reference disconnects the reference pin path.
// RQ12: Divider codes 1 to 7 divide pclk by 2 to 128; code 0 is reserved.
// RQ13: Software keeps the converter clock period inside its permitted range.
// RQ14: Software waits a settling delay after enabling before starting a conversion.
// RQ15: Software should clear enable when the converter is unused to save power.
// RQ16: The secondary control register is fully read-write and resets to zero.
// RQ17: A conversion takes 4 sampling plus 12 converting ticks, 16 in all.
// RQ18: Unused result bits read as zero in both formats.
// RQ19: A start sequence arriving while busy is ignored.
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module asc_adc_sequencer_control (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [asc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Converter core.
  input wire logic [asc_pkg::RESULT_W-1:0] conv_result,
  output asc_pkg::asc_analog_type analog_ctrl,
  // Interrupts.
  output logic conv_done_pulse,
  output logic irq
);
  import asc_pkg::*;

  asc_state_type s_reg;
  asc_state_type s_next;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [DIV_CNT_W-1:0] div_mask(input logic [DIV_W-1:0] code);
    logic [DIV_CNT_W-1:0] m;
    m = '0;
    case (code)
      3'h0: m = 7'h01; // Reserved code behaves as the smallest ratio.
      3'h1: m = 7'h01;
      3'h2: m = 7'h03;
      3'h3: m = 7'h07;
      3'h4: m = 7'h0F;
      3'h5: m = 7'h1F;
      3'h6: m = 7'h3F;
      3'h7: m = 7'h7F;
      default: m = 7'h01;
    endcase
    return m;
  endfunction : div_mask

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return (a == OFF_CTRL_PRIMARY) || (a == OFF_CTRL_SECONDARY) || (a == OFF_RESULT_HIGH) ||
           (a == OFF_RESULT_LOW) || (a == OFF_IRQ_STATUS) || (a == OFF_IRQ_CLEAR) ||
           (a == OFF_IRQ_ENABLE);
  endfunction : mapped

  logic [SRC_W-1:0] src;
  logic [REF_W-1:0] refsel;
  logic internal_src;
  logic busy;
  logic tick;
  logic [7:0] res_high;
  logic [7:0] res_low;

  assign src = s_reg.ctrl_secondary[SRC_LSB +: SRC_W];
  assign refsel = s_reg.ctrl_secondary[REF_LSB +: REF_W];
  assign internal_src = (src == SRC_BANDGAP) || ((src >= SRC_GROUND_FIRST) && (src <= SRC_GROUND_LAST)); // [RQ8]
  assign busy = (s_reg.phase != PH_IDLE);
  assign tick = busy &&
    ((s_reg.div_cnt & div_mask(s_reg.ctrl_secondary[DIV_LSB +: DIV_W])) ==
     div_mask(s_reg.ctrl_secondary[DIV_LSB +: DIV_W])); // [RQ12]

  // Result layout chosen by the live format bit; unused bits are zero.
  always_comb begin
    if (s_reg.format) begin
      res_high = {4'h0, s_reg.result[11:8]}; // [RQ6] [RQ18]
      res_low = s_reg.result[7:0];
    end else begin
      res_high = s_reg.result[11:4]; // [RQ6]
      res_low = {s_reg.result[3:0], 4'h0}; // [RQ18]
    end
  end

  // ---------------------------------------------------------------------------
  // Analog routing
  // ---------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < N_EXT_CH; g++) begin : g_ext
      // Codes 8 and up match no line, so the input floats.
      assign analog_ctrl.ext_select[g] = !internal_src &&
        (s_reg.chan == CHAN_W'(g)); // [RQ7] [RQ9]
    end
  endgenerate

  assign analog_ctrl.bandgap_select = (src == SRC_BANDGAP); // [RQ8]
  assign analog_ctrl.ground_select = internal_src && (src != SRC_BANDGAP); // [RQ8]
  assign analog_ctrl.ref_supply_select = (refsel == REF_SUPPLY); // [RQ10]
  assign analog_ctrl.ref_pin_connect = (refsel != REF_SUPPLY); // [RQ10] [RQ11]
  assign analog_ctrl.power_on = s_reg.enable; // [RQ5]
  assign analog_ctrl.conv_clk_tick = tick;
  assign analog_ctrl.sampling = (s_reg.phase == PH_SAMPLE);
  assign analog_ctrl.converting = (s_reg.phase == PH_CONVERT);

  // ---------------------------------------------------------------------------
  // Bus answer and interrupt outputs
  // ---------------------------------------------------------------------------
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);
  assign prdata = s_reg.prdata;
  assign conv_done_pulse = s_reg.done_pulse; // [RQ3]
  assign irq = |(s_reg.irq_status & s_reg.irq_enable);

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    logic wr;
    logic [N_EVENTS-1:0] ev;
    logic [N_EVENTS-1:0] clr;
    logic new_start;
    logic new_enable;
    wr = psel && penable && pwrite && mapped(paddr);
    ev = '0;
    clr = '0;
    new_start = s_reg.start;
    new_enable = s_reg.enable;
    s_next = s_reg;
    s_next.done_pulse = 1'b0;

    // -------------------------------------------------------------------------
    // Register writes
    // -------------------------------------------------------------------------
    // The start bit is compared against the value being written in this same
    // cycle, so a rise and fall in two writes is seen without any extra delay.
    if (wr && (paddr == OFF_CTRL_PRIMARY)) begin
      new_start = pwdata[START_BIT];
      new_enable = pwdata[ENABLE_BIT];
      s_next.start = new_start;
      s_next.enable = new_enable;
      s_next.format = pwdata[FORMAT_BIT];
      s_next.chan = pwdata[CHAN_LSB +: CHAN_W];
    end
    if (wr && (paddr == OFF_CTRL_SECONDARY)) begin
      s_next.ctrl_secondary = pwdata[7:0]; // [RQ16]
    end
    if (wr && (paddr == OFF_IRQ_ENABLE)) begin
      s_next.irq_enable = pwdata[N_EVENTS-1:0];
    end
    if (wr && (paddr == OFF_IRQ_CLEAR)) begin
      clr = pwdata[N_EVENTS-1:0];
    end

    // -------------------------------------------------------------------------
    // Sequencer
    // -------------------------------------------------------------------------
    // The divider count restarts with each conversion, so the first converter
    // tick always comes one full ratio after the start.
    if (busy) begin
      s_next.div_cnt = s_reg.div_cnt + 7'h01;
    end
    case (s_reg.phase)
      PH_IDLE: begin
        // A falling start bit after it was high ends the start sequence.
        if (s_reg.start && !new_start && new_enable) begin // [RQ1]
          s_next.phase = PH_SAMPLE; // [RQ2]
          s_next.tick_cnt = '0;
          s_next.div_cnt = '0;
        end
      end
      PH_SAMPLE: begin
        if (tick) begin
          if (s_reg.tick_cnt == SAMPLE_TICKS - 4'h1) begin // [RQ17]
            s_next.phase = PH_CONVERT;
            s_next.tick_cnt = '0;
          end else begin
            s_next.tick_cnt = s_reg.tick_cnt + 4'h1;
          end
        end
      end
      PH_CONVERT: begin
        if (tick) begin
          if (s_reg.tick_cnt == CONVERT_TICKS - 4'h1) begin // [RQ17]
            s_next.phase = PH_IDLE; // [RQ2]
            s_next.result = conv_result;
            s_next.done_pulse = 1'b1; // [RQ3]
            ev[EV_DONE] = 1'b1; // [RQ3]
          end else begin
            s_next.tick_cnt = s_reg.tick_cnt + 4'h1;
          end
        end
      end
      default: s_next.phase = PH_IDLE;
    endcase

    // A start sequence while busy is dropped and reported, except in the completion cycle, where it is dropped unreported.
    if (busy && s_reg.start && !new_start && !ev[EV_DONE]) begin // [RQ19]
      ev[EV_START_IGNORED] = 1'b1;
    end

    // Switching off aborts the conversion and leaves the results untouched.
    if (!new_enable) begin // [RQ5]
      s_next.phase = PH_IDLE;
      s_next.result = s_reg.result;
      s_next.done_pulse = 1'b0;
      ev[EV_DONE] = 1'b0;
    end

    // -------------------------------------------------------------------------
    // Interrupt status
    // -------------------------------------------------------------------------
    // Sticky flags: a new event wins over a clear in the same cycle.
    s_next.irq_status = (s_reg.irq_status & ~clr) | ev; // [RQ3]

    // -------------------------------------------------------------------------
    // Read data
    // -------------------------------------------------------------------------
    // Read data is captured in the setup phase and held through the access phase.
    if (psel && !penable) begin
      s_next.prdata = '0;
      case (paddr)
        OFF_CTRL_PRIMARY: begin
          s_next.prdata[START_BIT] = s_reg.start;
          s_next.prdata[BUSY_BIT] = busy; // [RQ2]
          s_next.prdata[ENABLE_BIT] = s_reg.enable;
          s_next.prdata[FORMAT_BIT] = s_reg.format;
          s_next.prdata[CHAN_LSB +: CHAN_W] = s_reg.chan;
        end
        OFF_CTRL_SECONDARY: s_next.prdata[7:0] = s_reg.ctrl_secondary; // [RQ16]
        OFF_RESULT_HIGH: s_next.prdata[7:0] = res_high;
        OFF_RESULT_LOW: s_next.prdata[7:0] = res_low;
        OFF_IRQ_STATUS: s_next.prdata[N_EVENTS-1:0] = s_reg.irq_status;
        OFF_IRQ_ENABLE: s_next.prdata[N_EVENTS-1:0] = s_reg.irq_enable;
        default: s_next.prdata = '0;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= ASC_STATE_RESET; // [RQ16]
    end else begin
      s_reg <= s_next;
    end
  end

endmodule : asc_adc_sequencer_control

`default_nettype wire

// ### src/asc_pkg.sv
// Purpose: Shared constants and types for the converter sequencer control block.
// Assumes: 32-bit APB register access, 200 MHz pclk, one converter core on pclk.
// Notes:   Register offsets are byte addresses of aligned 32-bit words.
package asc_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_CTRL_PRIMARY = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CTRL_SECONDARY = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_RESULT_HIGH = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_RESULT_LOW = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 8'h18;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int START_BIT = 7;
  localparam int BUSY_BIT = 6;
  localparam int ENABLE_BIT = 5;
  localparam int FORMAT_BIT = 4;
  localparam int CHAN_LSB = 0;
  localparam int CHAN_W = 4;
  localparam int SRC_LSB = 5;
  localparam int SRC_W = 3;
  localparam int REF_LSB = 3;
  localparam int REF_W = 2;
  localparam int DIV_LSB = 0;
  localparam int DIV_W = 3;
  localparam int RESULT_W = 12;
  localparam int N_EXT_CH = 8;
  localparam int N_EVENTS = 2;
  localparam int EV_DONE = 0;
  localparam int EV_START_IGNORED = 1;

  // ---------------------------------------------------------------------------
  // Encodings and timing
  // ---------------------------------------------------------------------------
  localparam logic [SRC_W-1:0] SRC_BANDGAP = 3'h1;
  localparam logic [SRC_W-1:0] SRC_GROUND_FIRST = 3'h2;
  localparam logic [SRC_W-1:0] SRC_GROUND_LAST = 3'h4;
  localparam logic [REF_W-1:0] REF_SUPPLY = 2'h1;
  localparam int DIV_CNT_W = 7;
  localparam int TICK_CNT_W = 4;
  localparam logic [TICK_CNT_W-1:0] SAMPLE_TICKS = 4'h4;
  localparam logic [TICK_CNT_W-1:0] CONVERT_TICKS = 4'hC;

  typedef enum logic [1:0] {PH_IDLE, PH_SAMPLE, PH_CONVERT} asc_phase_type;

  typedef struct packed {
    asc_phase_type phase;
    logic [TICK_CNT_W-1:0] tick_cnt;
    logic [DIV_CNT_W-1:0] div_cnt;
    logic start;
    logic enable;
    logic format;
    logic [CHAN_W-1:0] chan;
    logic [7:0] ctrl_secondary;
    logic [RESULT_W-1:0] result;
    logic [N_EVENTS-1:0] irq_status;
    logic [N_EVENTS-1:0] irq_enable;
    logic [31:0] prdata;
    logic done_pulse;
  } asc_state_type;

  localparam asc_state_type ASC_STATE_RESET = '{phase: PH_IDLE, default: '0};

  typedef struct packed {
    logic [N_EXT_CH-1:0] ext_select;
    logic bandgap_select;
    logic ground_select;
    logic ref_supply_select;
    logic ref_pin_connect;
    logic power_on;
    logic conv_clk_tick;
    logic sampling;
    logic converting;
  } asc_analog_type;

endpackage : asc_pkg

// ### testbench/asc_adc_sequencer_control_properties.sv
// Purpose: Port-level properties of the converter control block.
// Assumes: One pclk domain; presetn is asynchronous and active low.
// Notes:   Bound to the design top after the module.
`timescale 1ns/1ps
`default_nettype none
module asc_adc_sequencer_control_properties (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [asc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Converter and interrupts.
  input wire logic [asc_pkg::RESULT_W-1:0] conv_result,
  input wire asc_pkg::asc_analog_type analog_ctrl,
  input wire logic conv_done_pulse,
  input wire logic irq
);
  import asc_pkg::*;
  logic [4:0] tick_reg;
  logic [4:0] tick_next;
  logic busy;
  assign busy = analog_ctrl.sampling || analog_ctrl.converting;
  assign tick_next = busy ? tick_reg + 5'(analog_ctrl.conv_clk_tick) : 5'h00;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tick_reg <= 5'h00;
    else tick_reg <= tick_next;
  end
  // Shadow of the secondary control register, rebuilt from completed bus writes.
  logic [7:0] sec_reg;
  logic [7:0] sec_next;
  assign sec_next = (psel && penable && pwrite && (paddr == OFF_CTRL_SECONDARY)) ? pwdata[7:0] : sec_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sec_reg <= 8'h00;
    else sec_reg <= sec_next;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_conv_exit;
    $past(analog_ctrl.converting) && !analog_ctrl.converting;
  endsequence
  chk_done_one_cycle: assert property (conv_done_pulse |=> !conv_done_pulse)
    else $error("done pulse longer than one cycle");
  chk_done_ends_conv: assert property (conv_done_pulse |-> s_conv_exit)
    else $error("done pulse without end of conversion");
  chk_tick_total: assert property (conv_done_pulse |-> tick_reg == 5'h10)
    else $error("conversion tick count wrong");
  chk_sample_first: assert property ($rose(analog_ctrl.converting) |-> $past(analog_ctrl.sampling))
    else $error("converting without sampling first");
  chk_tick_busy: assert property (analog_ctrl.conv_clk_tick |-> busy)
    else $error("converter tick while idle");
  chk_ext_cut: assert property (analog_ctrl.bandgap_select || analog_ctrl.ground_select |->
    analog_ctrl.ext_select == 8'h00)
    else $error("external input joined to internal source");
  chk_ext_onehot: assert property ($onehot0(analog_ctrl.ext_select))
    else $error("more than one external channel");
  chk_src_excl: assert property (!(analog_ctrl.bandgap_select && analog_ctrl.ground_select))
    else $error("bandgap and ground together");
  chk_ref_excl: assert property (analog_ctrl.ref_supply_select != analog_ctrl.ref_pin_connect)
    else $error("reference path selection wrong");
  chk_ref_decode: assert property (analog_ctrl.ref_supply_select ==
    (sec_reg[REF_LSB +: REF_W] == REF_SUPPLY))
    else $error("reference selection does not follow the register");
  chk_bandgap_decode: assert property (analog_ctrl.bandgap_select ==
    (sec_reg[SRC_LSB +: SRC_W] == SRC_BANDGAP))
    else $error("bandgap selection does not follow the register");
endmodule : asc_adc_sequencer_control_properties
bind asc_adc_sequencer_control asc_adc_sequencer_control_properties u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .conv_result(conv_result), .analog_ctrl(analog_ctrl),
  .conv_done_pulse(conv_done_pulse), .irq(irq));
`default_nettype wire

// ### testbench/asc_adc_sequencer_control_tb.sv
// Purpose: Self-checking bench for the converter control block.
// Assumes: Zero-wait APB, result sampled at completion.
// Notes:   Reads are checked by a monitor from a queue of notes.
`timescale 1ns/1ps
`default_nettype none
module asc_adc_sequencer_control_tb;
  import asc_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, conv_done_pulse, irq, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [11:0] conv_result = 12'h000;
  logic [63:0] e;
  asc_analog_type analog_ctrl;
  logic [63:0] rq[$];
  int lq[$];
  int miscompares = 0, total_checks = 0, cyc = 0, t0 = 0;
  // Settling time granted after power-up before a start; a plain default.
  localparam int SETTLE_CYCLES = 20;
  asc_adc_sequencer_control dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_result(conv_result), .analog_ctrl(analog_ctrl), .conv_done_pulse(conv_done_pulse), .irq(irq));
  initial forever #2.5 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] x);
    total_checks++;
    if (s !== x) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, x, s);
    end
  endtask : check
  task automatic summarize;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    rq.push_back({m, x});
    apb(1'b0, a, 32'h0);
  endtask : rd
  // ---------------------------------------------------------------------------
  // Monitor: reads in the access phase, latency at each completion.
  // ---------------------------------------------------------------------------
  always @(negedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      e = rq.pop_front();
      if (e[63:32] != 32'h0) check("prdata", prdata & e[63:32], e[31:0]);
    end
    if (conv_done_pulse === 1'b1) check("latency", 32'(cyc - t0), 32'(lq.pop_front()));
  end
  initial begin
    #200000;
    miscompares++;
    summarize();
  end
  initial begin
    logic [2:0] src;
    logic [1:0] rf;
    logic [3:0] ch;
    logic [11:0] d;
    logic [2:0] dv;
    logic fmt;
    int n;
    void'($urandom(43));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFF_CTRL_PRIMARY, 32'hFF, 32'h0);
    rd(OFF_CTRL_SECONDARY, 32'hFF, 32'h0);
    for (int c = 0; c < 8; c++) begin
      src = 3'($urandom);
      rf = 2'($urandom);
      ch = 4'($urandom);
      d = 12'($urandom);
      fmt = c[1];
      // The reserved divider code is never programmed; the slowest ratio stands in for it.
      dv = (c == 0) ? 3'h7 : 3'(c);
      apb(1'b1, OFF_IRQ_ENABLE, {31'h0, c[0]});
      apb(1'b1, OFF_CTRL_SECONDARY, {24'h0, src, rf, dv});
      rd(OFF_CTRL_SECONDARY, 32'hFF, {24'h0, src, rf, dv});
      conv_result <= d;
      apb(1'b1, OFF_CTRL_PRIMARY, {24'h0, 3'h1, fmt, ch});
      repeat (SETTLE_CYCLES) @(posedge pclk);
      apb(1'b1, OFF_CTRL_PRIMARY, {24'h0, 3'h5, fmt, ch});
      apb(1'b1, OFF_CTRL_PRIMARY, {24'h0, 3'h1, fmt, ch});
      #1;
      t0 = cyc;
      lq.push_back(16 << dv);
      check("bandgap", analog_ctrl.bandgap_select, src == 3'h1);
      check("ground", analog_ctrl.ground_select, src inside {[3'h2:3'h4]});
      check("ext", analog_ctrl.ext_select,
        (src inside {[3'h1:3'h4]} || ch[3]) ? 8'h00 : 8'h01 << ch[2:0]);
      check("ref", {analog_ctrl.ref_supply_select, analog_ctrl.ref_pin_connect},
        (rf == 2'h1) ? 2'h2 : 2'h1);
      check("power", analog_ctrl.power_on, 1'b1);
      rd(OFF_CTRL_PRIMARY, 32'h40, 32'h40);
      if (c == 7) begin
        apb(1'b1, OFF_CTRL_PRIMARY, {24'h0, 3'h5, fmt, ch});
        apb(1'b1, OFF_CTRL_PRIMARY, {24'h0, 3'h1, fmt, ch});
      end
      n = 0;
      do begin
        rd(OFF_CTRL_PRIMARY, 32'h0, 32'h0);
        n++;
      end while (q[6] !== 1'b0 && n < 1000);
      check("poll", q[6], 1'b0);
      rd(OFF_RESULT_HIGH, 32'hFF, fmt ? {28'h0, d[11:8]} : {24'h0, d[11:4]});
      rd(OFF_RESULT_LOW, 32'hFF, fmt ? {24'h0, d[7:0]} : {24'h0, d[3:0], 4'h0});
      rd(OFF_IRQ_STATUS, 32'h3, {30'h0, c == 7, 1'b1});
      check("irq", irq, c[0]);
      apb(1'b1, OFF_IRQ_CLEAR, 32'h3);
      rd(OFF_IRQ_STATUS, 32'h3, 32'h0);
      check("irq", irq, 1'b0);
    end
    conv_result <= ~d;
    apb(1'b1, OFF_CTRL_PRIMARY, 32'hA0);
    rd(OFF_CTRL_PRIMARY, 32'h40, 32'h0);
    // A conversion switched off while still sampling, before its first tick, must leave no result and no event.
    apb(1'b1, OFF_CTRL_PRIMARY, 32'h20);
    rd(OFF_CTRL_PRIMARY, 32'h40, 32'h40);
    apb(1'b1, OFF_CTRL_PRIMARY, 32'h80);
    apb(1'b1, OFF_CTRL_PRIMARY, 32'h00);
    rd(OFF_CTRL_PRIMARY, 32'h40, 32'h0);
    repeat (16 << dv) @(posedge pclk);
    rd(OFF_RESULT_HIGH, 32'hFF, {24'h0, d[11:4]});
    rd(OFF_IRQ_STATUS, 32'h3, 32'h0);
    check("power", analog_ctrl.power_on, 1'b0);
    // A reset after the aborted run, with the converter idle and off, returns every control field to zero.
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFF_CTRL_SECONDARY, 32'hFF, 32'h0);
    rd(OFF_CTRL_PRIMARY, 32'hFF, 32'h0);
    rd(8'h1C, 32'hFFFFFFFF, 32'h0);
    check("slverr", err, 1'b1);
    summarize();
  end
endmodule : asc_adc_sequencer_control_tb
`default_nettype wire
